// File: core/lcdsg_top.sv
/*
 * LCD drive signal generator: column nibble stream, shift and enable chain
 * clocks, line latch, frame signal, scan start, row clock and blanking.
 * Assumes commands arrive as one-cycle strobes from logic on ref_clk and
 * that the variant strap is an asynchronous pin.
 */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Column data leaves as 4-bit nibble
// - Nibble held valid at shift clock fall
// - Shift clock halts from latch to line
// - Enable chain pulse every 16 column pulses
// - One line latch pulse per line
// - Frame signal period selectable, two values
// - Row drivers capture scan pulse on fall
// - Scan start high during last line
// - Blank output high while drive active
// - Sleep drops blank within two frames
// - Blank power-up level set by variant
// - Init restarts timing, blanks, cancels sleep
module lcdsg_top (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // Variant strap: high starts with display on
    input  wire logic       variant_on_strap,
    // Command strobes
    input  wire logic       init_cmd,
    input  wire logic       init_ac_sel,
    input  wire logic       display_on_cmd,
    input  wire logic       sleep_cmd,
    // Pixel nibble stream
    input  wire logic [3:0] pix_data,
    input  wire logic       pix_valid,
    output logic            pix_ready,
    // Driver pins
    output logic [3:0]      column_data_nibble,
    output logic            column_shift_clock,
    output logic            enable_chain_clock,
    output logic            line_latch_pulse,
    output logic            ac_frame_signal,
    output logic            row_shift_clock,
    output logic            scan_start_pulse,
    output logic            row_blank_output
);
    localparam logic [6:0] NIB_LAST  = 7'(lcdsg_pkg::NIB_PER_LINE - 1);
    localparam logic [7:0] LINE_LAST = 8'(lcdsg_pkg::LINES_PER_FRAME - 1);
    localparam logic [3:0] DRV_LAST  = 4'(lcdsg_pkg::NIB_PER_DRIVER - 1);
    localparam logic [2:0] LAT_LAST  = 3'(lcdsg_pkg::LATCH_CYC - 1);
    localparam logic [3:0] AC_LAST   = 4'(lcdsg_pkg::AC_LINES - 1);

    lcdsg_pkg::lcdsg_state_t state_q, state_d;
    logic [6:0] nib_cnt_q, nib_cnt_d;
    logic [7:0] line_q, line_d;
    logic [2:0] lat_cnt_q, lat_cnt_d;
    logic [3:0] ac_cnt_q, ac_cnt_d;
    logic [3:0] nib_q, nib_d;
    logic       sck_q, sck_d;
    logic       ecl_q, ecl_d;
    logic       lp_q, lp_d;
    logic       ac_q, ac_d;
    logic       ac_sel_q, ac_sel_d;
    logic       rsc_q, rsc_d;
    logic       blank_q, blank_d;
    logic       scan_q, scan_d;
    logic       sleep_q, sleep_d;
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic       strap_s1_q, strap_s2_q;
    logic       rise_tick, fall_tick, line_end, frame_end;

    lcdsg_clk_gen u_clk_gen (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .run       (state_q == lcdsg_pkg::LCDSG_XFER && !init_cmd),
        .rise_tick (rise_tick),
        .fall_tick (fall_tick)
    );

    assign pix_ready = rise_tick && !init_cmd;
    assign line_end  = clk_en && state_q == lcdsg_pkg::LCDSG_LATCH && lat_cnt_q == LAT_LAST;
    assign frame_end = line_end && line_q == LINE_LAST;

    always_comb begin
        state_d   = state_q;
        nib_cnt_d = nib_cnt_q;
        line_d    = line_q;
        lat_cnt_d = lat_cnt_q;
        ac_cnt_d  = ac_cnt_q;
        nib_d     = nib_q;
        sck_d     = sck_q;
        ecl_d     = ecl_q;
        lp_d      = lp_q;
        ac_d      = ac_q;
        ac_sel_d  = ac_sel_q;
        if (rise_tick) begin
            nib_d = pix_valid ? pix_data : lcdsg_pkg::NIB_RST;
            sck_d = 1'b1;
            ecl_d = (nib_cnt_q[3:0] == DRV_LAST);
        end
        if (fall_tick) begin
            sck_d     = 1'b0;
            ecl_d     = 1'b0;
            nib_cnt_d = nib_cnt_q + 7'h1;
            if (nib_cnt_q == NIB_LAST) begin
                state_d   = lcdsg_pkg::LCDSG_LATCH;
                lp_d      = 1'b1;
                lat_cnt_d = 3'h0;
                nib_cnt_d = 7'h0;
            end
        end
        if (clk_en && state_q == lcdsg_pkg::LCDSG_LATCH) begin
            lat_cnt_d = lat_cnt_q + 3'h1;
        end
        if (line_end) begin
            state_d  = lcdsg_pkg::LCDSG_XFER;
            lp_d     = 1'b0;
            line_d   = (line_q == LINE_LAST) ? 8'h00 : line_q + 8'h01;
            ac_cnt_d = (ac_cnt_q == AC_LAST) ? 4'h0 : ac_cnt_q + 4'h1;
            if (ac_sel_q ? (ac_cnt_q == AC_LAST) : (line_q == LINE_LAST)) begin
                ac_d = !ac_q;
            end
        end
        if (init_cmd && clk_en) begin
            state_d   = lcdsg_pkg::LCDSG_XFER;
            nib_cnt_d = 7'h0;
            line_d    = 8'h00;
            lat_cnt_d = 3'h0;
            ac_cnt_d  = 4'h0;
            sck_d     = 1'b0;
            ecl_d     = 1'b0;
            lp_d      = 1'b0;
            ac_d      = lcdsg_pkg::AC_RST;
            ac_sel_d  = init_ac_sel;
        end
    end

    always_comb begin
        rsc_d       = lp_d;
        // Scan held past row clock fall
        // Lags the line count one cycle so it still stands at the closing latch fall
        scan_d      = (line_q == LINE_LAST) && !init_cmd;
        blank_d     = blank_q;
        sleep_d     = sleep_q;
        strap_cnt_d = strap_cnt_q;
        if (clk_en) begin
            if (strap_cnt_q != 2'h3) begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end
            if (strap_cnt_q == 2'h2) begin
                blank_d = strap_s2_q;
            end
            if (display_on_cmd) begin
                blank_d = 1'b1;
            end
            if (sleep_cmd) begin
                sleep_d = 1'b1;
            end
            if (frame_end && sleep_q) begin
                blank_d = 1'b0;
            end
            if (init_cmd) begin
                blank_d = 1'b0;
                sleep_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q     <= lcdsg_pkg::LCDSG_XFER;
            nib_cnt_q   <= 7'h0;
            line_q      <= 8'h00;
            lat_cnt_q   <= 3'h0;
            ac_cnt_q    <= 4'h0;
            nib_q       <= lcdsg_pkg::NIB_RST;
            sck_q       <= 1'b0;
            ecl_q       <= 1'b0;
            lp_q        <= 1'b0;
            ac_q        <= lcdsg_pkg::AC_RST;
            ac_sel_q    <= 1'b0;
            rsc_q       <= 1'b0;
            scan_q      <= 1'b0;
            blank_q     <= 1'b0;
            sleep_q     <= 1'b0;
            strap_cnt_q <= 2'h0;
            strap_s1_q  <= 1'b0;
            strap_s2_q  <= 1'b0;
        end else if (clk_en) begin
            state_q     <= state_d;
            nib_cnt_q   <= nib_cnt_d;
            line_q      <= line_d;
            lat_cnt_q   <= lat_cnt_d;
            ac_cnt_q    <= ac_cnt_d;
            nib_q       <= nib_d;
            sck_q       <= sck_d;
            ecl_q       <= ecl_d;
            lp_q        <= lp_d;
            ac_q        <= ac_d;
            ac_sel_q    <= ac_sel_d;
            rsc_q       <= rsc_d;
            scan_q      <= scan_d;
            blank_q     <= blank_d;
            sleep_q     <= sleep_d;
            strap_cnt_q <= strap_cnt_d;
            strap_s1_q  <= variant_on_strap;
            strap_s2_q  <= strap_s1_q;
        end
    end

    assign column_data_nibble = nib_q;
    assign column_shift_clock = sck_q;
    assign enable_chain_clock = ecl_q;
    assign line_latch_pulse   = lp_q;
    assign ac_frame_signal    = ac_q;
    assign row_shift_clock    = rsc_q;
    assign scan_start_pulse   = scan_q;
    assign row_blank_output   = blank_q;

    // Frame ends seen while blank stays high with sleep pending
    logic [1:0] sleep_frames_q;
    always_ff @(posedge ref_clk) begin
        if (reset || !sleep_q || !blank_q) begin
            sleep_frames_q <= 2'h0;
        end else if (frame_end && sleep_frames_q != 2'h3) begin
            sleep_frames_q <= sleep_frames_q + 2'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_sck_halt_latch: assert property (state_q == lcdsg_pkg::LCDSG_LATCH |-> !sck_q)
        else $error("shift clock runs during latch");
    a_data_hold_fall: assert property ($fell(sck_q) |-> $stable(nib_q))
        else $error("nibble changed at capture edge");
    a_data_on_rise: assert property ($changed(nib_q) |-> $rose(sck_q))
        else $error("nibble changed off rising edge");
    a_chain_every16: assert property ($fell(ecl_q) |-> nib_cnt_q[3:0] == 4'h0)
        else $error("enable chain out of step");
    a_latch_once_line: assert property ($rose(lp_q) |-> $past(nib_cnt_q) == NIB_LAST)
        else $error("latch not after last nibble");
    a_scan_hold: assert property ($fell(rsc_q) |-> $stable(scan_q) || $past(init_cmd))
        else $error("scan start moved at row clock fall");
    a_scan_last: assert property ($rose(scan_q) |-> line_q == LINE_LAST)
        else $error("scan start outside last line");
    a_frame_sig_flip: assert property ($changed(ac_q) |-> $past(line_end) || $past(init_cmd))
        else $error("frame signal flipped mid line");
    a_sleep_blank_by2: assert property (sleep_frames_q < 2'h2)
        else $error("blank still high two frames after sleep");
    a_init_blanks: assert property (init_cmd && clk_en |=> !blank_q && !sleep_q)
        else $error("init did not blank display");

    c_line_done:  cover property (line_end);
    c_frame_done: cover property (frame_end);
    c_sleep_off:  cover property (sleep_q && $fell(blank_q));
    c_chain_tick: cover property ($fell(ecl_q));
endmodule
`default_nettype wire

// File: core/lcdsg_pkg.sv
/*
 * Constants and state type for the LCD drive signal generator.
 * Assumes one 100 MHz core clock; the cycle counts below are derived from its period.
 */
package lcdsg_pkg;
    // Core clock period in ns and column shift clock period in ns
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SCK_PERIOD_NS   = 40;
    localparam int SCK_DIV         = SCK_PERIOD_NS / CLK_PERIOD_NS;
    // Display geometry: nibbles per line and lines per frame
    localparam int NIB_PER_LINE    = 80;
    localparam int LINES_PER_FRAME = 240;
    // Pulses per column driver before the enable chain moves on
    localparam int NIB_PER_DRIVER  = 16;
    // Line latch pulse width in ns and in core cycles
    localparam int LATCH_NS        = 40;
    localparam int LATCH_CYC       = (LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Lines between frame signal flips in the short period mode
    localparam int AC_LINES        = 16;
    // Reset values
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic       AC_RST  = 1'b0;

    typedef enum logic [0:0] {
        LCDSG_XFER  = 1'b0,
        LCDSG_LATCH = 1'b1
    } lcdsg_state_t;
endpackage

// File: core/lcdsg_clk_gen.sv
/*
 * Column shift clock phase generator.
 * Assumes run is low whenever the line is not shifting; phase restarts then.
 */
`timescale 1ns/1ns
`default_nettype none
module lcdsg_clk_gen (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // Control
    input  wire logic run,
    // Edge strobes for the shift clock
    output logic      rise_tick,
    output logic      fall_tick
);
    localparam logic [1:0] PH_LAST = 2'(lcdsg_pkg::SCK_DIV - 1);
    localparam logic [1:0] PH_RISE = 2'(lcdsg_pkg::SCK_DIV / 2 - 1);

    logic [1:0] phase_q;
    logic [1:0] phase_d;

    always_comb begin
        phase_d = phase_q;
        if (!run) begin
            phase_d = 2'h0;
        end else if (phase_q == PH_LAST) begin
            phase_d = 2'h0;
        end else begin
            phase_d = phase_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_q <= 2'h0;
        end else if (clk_en) begin
            phase_q <= phase_d;
        end
    end

    assign rise_tick = run && clk_en && (phase_q == PH_RISE);
    assign fall_tick = run && clk_en && (phase_q == PH_LAST);
endmodule
`default_nettype wire

// File: verification/lcdsg_drv_model.sv
/*
 * Column and row driver model fed by the drive pins.
 * Assumes the line latch pulse is wired as the row clock.
 */
`timescale 1ns/1ns
`default_nettype none
module lcdsg_drv_model (
    // Column side
    input  wire logic [3:0] column_data_nibble,
    input  wire logic       column_shift_clock,
    input  wire logic       line_latch_pulse,
    // Row side
    input  wire logic       row_clock,
    input  wire logic       scan_start_pulse,
    input  wire logic       row_blank_output,
    // Observed state
    output logic [3:0]      cap_nib,
    output logic [7:0]      latched_cnt,
    output logic [7:0]      row_out
);
    logic [7:0] fall_total = 8'h00;
    logic [7:0] fall_base  = 8'h00;
    logic [7:0] row_sr     = 8'h00;
    always @(negedge column_shift_clock) begin
        cap_nib <= column_data_nibble;
        fall_total <= fall_total + 8'h01;
    end
    // transfer on fall; shifts counted since the previous latch
    always @(negedge line_latch_pulse) begin
        latched_cnt <= fall_total - fall_base;
        fall_base <= fall_total;
    end
    // scan capture on row clock fall
    always @(negedge row_clock) begin
        row_sr <= {row_sr[6:0], scan_start_pulse};
    end
    assign row_out = row_blank_output ? row_sr : 8'h00;
endmodule
`default_nettype wire

// File: verification/tb_lcdsg_top.sv
/*
 * Self-checking bench for the LCD drive signal generator.
 * Assumes commands are one-cycle strobes; clk_en is high except in the clock enable test.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_lcdsg_top;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic       clk_en = 1'b1;
    logic       variant_on_strap = 1'b1;
    logic       init_cmd = 1'b0;
    logic       init_ac_sel = 1'b0;
    logic       display_on_cmd = 1'b0;
    logic       sleep_cmd = 1'b0;
    logic [3:0] pix_data = 4'h0;
    logic       pix_valid = 1'b0;
    logic       pix_ready, column_shift_clock, enable_chain_clock, line_latch_pulse;
    logic       ac_frame_signal, row_shift_clock, scan_start_pulse, row_blank_output;
    logic [3:0] column_data_nibble, cap_nib;
    logic [7:0] latched_cnt, row_out;
    logic [15:0] lfsr = 16'hEB86;
    logic       ecl_q = 1'b0;
    logic       lat_q = 1'b0;
    logic [7:0] snap = 8'h00;
    int         n_fail = 0;
    int         n_tests = 0;
    int         line_nib = 0;
    int         lines = 0;
    logic [3:0] exp_q[$];

    always #5 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    lcdsg_top dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .variant_on_strap(variant_on_strap), .init_cmd(init_cmd), .init_ac_sel(init_ac_sel),
        .display_on_cmd(display_on_cmd), .sleep_cmd(sleep_cmd), .pix_data(pix_data),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .column_data_nibble(column_data_nibble),
        .column_shift_clock(column_shift_clock), .enable_chain_clock(enable_chain_clock),
        .line_latch_pulse(line_latch_pulse), .ac_frame_signal(ac_frame_signal),
        .row_shift_clock(row_shift_clock), .scan_start_pulse(scan_start_pulse),
        .row_blank_output(row_blank_output));

    lcdsg_drv_model drv (.column_data_nibble(column_data_nibble),
        .column_shift_clock(column_shift_clock), .line_latch_pulse(line_latch_pulse),
        .row_clock(line_latch_pulse), .scan_start_pulse(scan_start_pulse),
        .row_blank_output(row_blank_output), .cap_nib(cap_nib), .latched_cnt(latched_cnt),
        .row_out(row_out));

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Random pixel stream and reference queue of nibbles sent
    always @(posedge ref_clk) begin
        lfsr <= lfsr_next(lfsr);
        pix_data <= lfsr[3:0];
        pix_valid <= lfsr[7:4] != 4'h0;
        ecl_q <= enable_chain_clock;
        lat_q <= line_latch_pulse;
        if (!reset && pix_ready === 1'b1) begin
            exp_q.push_back(pix_valid ? pix_data : 4'h0);
            line_nib <= line_nib + 1;
        end
        if (enable_chain_clock === 1'b1 && !ecl_q)
            chk(8'(line_nib % 16 == 0 && line_nib > 0), 8'h01, "chain spacing");
        if (line_latch_pulse === 1'b1 && !lat_q) begin
            chk(8'(line_nib), 8'h50, "nibbles per line");
            chk(8'(row_shift_clock), 8'h01, "row clock with latch");
        end
        if (line_latch_pulse === 1'b0 && lat_q)
            chk(8'(row_shift_clock), 8'h00, "row clock after latch");
        if (line_latch_pulse === 1'b1) begin
            chk(8'(column_shift_clock), 8'h00, "clock halted");
            line_nib <= 0;
        end
        if (init_cmd === 1'b1 || reset === 1'b1) begin
            line_nib <= 0;
            exp_q.delete();
        end
    end

    always @(negedge column_shift_clock) begin
        #1;
        if (exp_q.size() > 0)
            chk(8'(cap_nib), 8'(exp_q.pop_front()), "nibble");
    end

    task cmd(input int which, input logic sel);
        @(posedge ref_clk);
        init_cmd <= (which == 0);
        init_ac_sel <= sel;
        display_on_cmd <= (which == 1);
        sleep_cmd <= (which == 2);
        @(posedge ref_clk);
        init_cmd <= 1'b0;
        display_on_cmd <= 1'b0;
        sleep_cmd <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task wait_line;
        int i;
        i = 0;
        while (line_latch_pulse !== 1'b1 && i < 2000) begin
            @(posedge ref_clk);
            i++;
        end
        while (line_latch_pulse !== 1'b0 && i < 2000) begin
            @(posedge ref_clk);
            i++;
        end
        if (i >= 2000) begin
            n_fail++;
            $display("wrong value at %0t: no line end seen", $time);
            finish_test;
        end
        repeat (2) @(posedge ref_clk);
        #1;
        if (lines > 0)
            chk(latched_cnt, 8'h50, "latched count");
        lines++;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk(8'(row_blank_output), 8'h01, "strap level");
        $display("test power-up done");
        wait_line;
        cmd(0, 1'b0);
        chk(8'(row_blank_output), 8'h00, "init blanks");
        cmd(1, 1'b0);
        chk(8'(row_blank_output), 8'h01, "display on");
        lines = 0;
        for (int k = 0; k < 240; k++) begin
            repeat (100) @(posedge ref_clk);
            #1;
            chk(8'(scan_start_pulse), 8'(k == 239), "scan start");
            chk(8'(ac_frame_signal), 8'h00, "frame signal hold");
            chk(8'(row_blank_output), 8'h01, "blank while driving");
            if (k == 120)
                cmd(2, 1'b0);
            wait_line;
        end
        chk(8'(ac_frame_signal), 8'h01, "frame signal flip");
        chk(8'(row_blank_output), 8'h00, "sleep blanks");
        chk(row_out, 8'h00, "rows deselected");
        $display("test frame and sleep done");
        cmd(0, 1'b1);
        chk(8'(ac_frame_signal), 8'h00, "init frame signal");
        cmd(1, 1'b0);
        chk(8'(row_blank_output), 8'h01, "sleep cancelled");
        lines = 0;
        for (int k = 0; k < 36; k++) begin
            repeat (100) @(posedge ref_clk);
            #1;
            chk(8'(ac_frame_signal), 8'((k / 16) % 2), "short frame signal");
            wait_line;
        end
        $display("test short frame signal done");
        // Clock enable low must hold the nibble, shift clock, latch, frame signal and blank pins
        @(posedge ref_clk);
        clk_en <= 1'b0;
        @(posedge ref_clk);
        #1;
        snap = {column_data_nibble, column_shift_clock, line_latch_pulse, ac_frame_signal,
                row_blank_output};
        repeat (20) @(posedge ref_clk);
        #1;
        chk({column_data_nibble, column_shift_clock, line_latch_pulse, ac_frame_signal,
             row_blank_output}, snap, "frozen by enable");
        @(posedge ref_clk);
        clk_en <= 1'b1;
        $display("test clock enable done");
        // Second reset in mid-run with the other strap level
        @(posedge ref_clk);
        reset <= 1'b1;
        variant_on_strap <= 1'b0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk(8'(row_blank_output), 8'h00, "strap low level");
        chk(8'(line_latch_pulse), 8'h00, "latch after reset");
        $display("test reset and strap done");
        finish_test;
    end
endmodule
`default_nettype wire
